//--- cpu_register_file.sv
// cpu register file: two banks, pointers, stack pointers and flag word
// assumes the core drives its write port and alu flags on clk_i
//
// The implementer's own choices: the strobed register port and the register addresses.
module cpu_register_file
    import cpu_regs_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    // software register port
    input wire logic [cpu_regs_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [cpu_regs_pkg::LONG_W-1:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    output logic [cpu_regs_pkg::LONG_W-1:0] reg_rdata_o,
    // core operand write port
    input wire logic core_we_i,
    input wire logic [3:0] core_wsel_i,
    input wire logic [cpu_regs_pkg::DATA_W-1:0] core_wdata_i,
    input wire logic pair_we_i,
    input wire logic [1:0] pair_wsel_i,
    input wire logic [31:0] pair_wdata_i,
    input wire logic pc_load_i,
    input wire logic [cpu_regs_pkg::LONG_W-1:0] pc_next_i,
    // alu flag update
    input wire logic alu_update_i,
    input wire logic alu_carry_i,
    input wire logic alu_overflow_i,
    input wire logic [cpu_regs_pkg::DATA_W-1:0] alu_result_i,
    // core read ports
    input wire logic [3:0] core_rsel_i,
    output logic [cpu_regs_pkg::DATA_W-1:0] core_rdata_o,
    output logic [31:0] data_pair_even_o,
    output logic [31:0] data_pair_odd_o,
    output logic [31:0] addr_pair_long_o,
    output logic [cpu_regs_pkg::DATA_W-1:0] frame_base_o,
    output logic [cpu_regs_pkg::DATA_W-1:0] static_base_o,
    output logic [cpu_regs_pkg::DATA_W-1:0] active_sp_o,
    output logic [cpu_regs_pkg::LONG_W-1:0] vector_base_o,
    output logic [cpu_regs_pkg::LONG_W-1:0] instr_ptr_o,
    output logic [cpu_regs_pkg::FLAG_W-1:0] flag_word_o
);
    import cpu_regs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // storage
    // two banked copies
    logic [DATA_W-1:0] bank [NUM_BANKS][NUM_BANKED];
    logic [LONG_W-1:0] vector_table_base;
    logic [LONG_W-1:0] next_instr_pointer;
    logic [DATA_W-1:0] user_stack_ptr;
    logic [DATA_W-1:0] interrupt_stack_ptr;
    logic [DATA_W-1:0] static_base_reg;
    logic [FLAG_W-1:0] cpu_flag_word;
    logic [LONG_W-1:0] rdata;

    ////////////////////////////////////////////////////////////////////////////
    // selection
    // bank pick
    wire logic bank_sel = cpu_flag_word[FLAG_BANK];
    wire logic stack_sel = cpu_flag_word[FLAG_STACK];
    wire logic [DATA_W-1:0] data_reg_zero = bank[bank_sel][0];
    wire logic [DATA_W-1:0] data_reg_one = bank[bank_sel][1];
    wire logic [DATA_W-1:0] data_reg_two = bank[bank_sel][2];
    wire logic [DATA_W-1:0] data_reg_three = bank[bank_sel][3];
    wire logic [DATA_W-1:0] addr_reg_zero = bank[bank_sel][4];
    wire logic [DATA_W-1:0] addr_reg_one = bank[bank_sel][5];
    wire logic [DATA_W-1:0] frame_base_reg = bank[bank_sel][6];
    wire logic [DATA_W-1:0] active_sp = stack_sel ? user_stack_ptr : interrupt_stack_ptr;
    wire logic sw_banked = reg_write_i && (reg_addr_i <= IDX_FRAME_BASE);
    wire logic [2:0] sw_slot = reg_addr_i[2:0];
    wire logic [2:0] core_slot = core_wsel_i[2:0];
    wire logic core_banked = core_we_i && (core_wsel_i <= 4'(SEL_ONE_UPPER));
    wire logic core_addr = core_we_i && (core_wsel_i >= 4'(SEL_ADDR_ZERO))
        && (core_wsel_i <= 4'(SEL_FRAME_BASE));

    ////////////////////////////////////////////////////////////////////////////
    // banked registers
    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
        for (genvar r = 0; r < NUM_BANKED; r++) begin : g_reg
            logic [DATA_W-1:0] next_val;
            always_comb begin
                next_val = bank[b][r];
                if (bank_sel == 1'(b)) begin
                    if (sw_banked && sw_slot == 3'(r)) begin
                        next_val = reg_wdata_i[DATA_W-1:0];
                    end else if (core_banked && core_wsel_i <= 4'(SEL_DATA_THREE)
                        && core_slot == 3'(r)) begin
                        next_val = core_wdata_i;
                    end else if (core_banked && core_wsel_i >= 4'(SEL_ZERO_LOWER)
                        && 3'(r) == {2'b00, core_wsel_i[1]}) begin
                        if (core_wsel_i[0]) begin
                            next_val = {core_wdata_i[7:0], bank[b][r][7:0]};
                        end else begin
                            next_val = {bank[b][r][15:8], core_wdata_i[7:0]};
                        end
                    // address and frame base as operands
                    end else if (core_addr && 3'(core_wsel_i - 4'(SEL_ADDR_ZERO)) + 3'd4
                        == 3'(r)) begin
                        next_val = core_wdata_i;
                    end else if (pair_we_i && pair_wsel_i[1] == 1'b0 && r < 4
                        && 1'(r % 2) == pair_wsel_i[0]) begin
                        next_val = r >= 2 ? pair_wdata_i[31:16] : pair_wdata_i[15:0];
                    end else if (pair_we_i && pair_wsel_i == 2'b10 && (r == 4 || r == 5)) begin
                        next_val = r == 5 ? pair_wdata_i[31:16] : pair_wdata_i[15:0];
                    end
                end
            end
            always_ff @(posedge clk_i) begin
                if (!resetn_i) begin
                    bank[b][r] <= RESET_WORD;
                end else begin
                    bank[b][r] <= next_val;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // unbanked registers
    wire logic sw_vec = reg_write_i && reg_addr_i == IDX_VECTOR_BASE;
    wire logic sw_pc = reg_write_i && reg_addr_i == IDX_INSTR_PTR;
    wire logic sw_usp = reg_write_i && reg_addr_i == IDX_USER_SP;
    wire logic sw_isp = reg_write_i && reg_addr_i == IDX_INTR_SP;
    wire logic sw_asp = reg_write_i && reg_addr_i == IDX_ACTIVE_SP;
    wire logic core_asp = core_we_i && core_wsel_i == 4'(SEL_ACTIVE_SP);
    wire logic sw_sb = reg_write_i && reg_addr_i == IDX_STATIC_BASE;
    wire logic core_sb = core_we_i && core_wsel_i == 4'(SEL_STATIC_BASE);
    wire logic sw_flg = reg_write_i && reg_addr_i == IDX_FLAG_WORD;
    wire logic [DATA_W-1:0] sp_wdata = sw_asp ? reg_wdata_i[DATA_W-1:0] : core_wdata_i;
    // active stack pointer writes follow the stack bit, direct user and interrupt sp writes do not
    wire logic usp_we = sw_usp || ((sw_asp || core_asp) && stack_sel);
    wire logic isp_we = sw_isp || ((sw_asp || core_asp) && !stack_sel);
    wire logic [DATA_W-1:0] next_usp = sw_usp ? reg_wdata_i[DATA_W-1:0] : sp_wdata;
    wire logic [DATA_W-1:0] next_isp = sw_isp ? reg_wdata_i[DATA_W-1:0] : sp_wdata;
    wire logic [DATA_W-1:0] next_sb = sw_sb ? reg_wdata_i[DATA_W-1:0] : core_wdata_i;
    // software or core load of the program counter
    wire logic [LONG_W-1:0] next_pc = sw_pc ? reg_wdata_i : pc_next_i;

    // flag update: software write first, alu result overrides arithmetic flags
    logic [FLAG_W-1:0] next_flags;
    always_comb begin
        next_flags = cpu_flag_word;
        if (sw_flg) begin
            next_flags = reg_wdata_i[FLAG_W-1:0] & FLAG_WRITE_MASK;
        end
        if (alu_update_i) begin
            next_flags[FLAG_CARRY] = alu_carry_i;
            next_flags[FLAG_ZERO] = (alu_result_i == RESET_WORD);
            next_flags[FLAG_SIGN] = alu_result_i[DATA_W-1];
            next_flags[FLAG_OVFL] = alu_overflow_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            vector_table_base <= RESET_LONG;
            next_instr_pointer <= RESET_LONG;
            user_stack_ptr <= RESET_WORD;
            interrupt_stack_ptr <= RESET_WORD;
            static_base_reg <= RESET_WORD;
            cpu_flag_word <= RESET_FLAGS;
        end else begin
            if (sw_vec) begin
                vector_table_base <= reg_wdata_i;
            end
            if (sw_pc || pc_load_i) begin
                next_instr_pointer <= next_pc;
            end
            if (usp_we) begin
                user_stack_ptr <= next_usp;
            end
            if (isp_we) begin
                interrupt_stack_ptr <= next_isp;
            end
            if (sw_sb || core_sb) begin
                static_base_reg <= next_sb;
            end
            cpu_flag_word <= next_flags;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // software read port, data one cycle after the strobe
    wire logic [LONG_W-1:0] rd_banked = {4'h0, bank[bank_sel][sw_slot]};
    wire logic [LONG_W-1:0] rd_value =
        (reg_addr_i <= IDX_FRAME_BASE) ? rd_banked :
        (reg_addr_i == IDX_VECTOR_BASE) ? vector_table_base :
        (reg_addr_i == IDX_INSTR_PTR) ? next_instr_pointer :
        (reg_addr_i == IDX_USER_SP) ? {4'h0, user_stack_ptr} :
        (reg_addr_i == IDX_INTR_SP) ? {4'h0, interrupt_stack_ptr} :
        (reg_addr_i == IDX_STATIC_BASE) ? {4'h0, static_base_reg} :
        (reg_addr_i == IDX_FLAG_WORD) ? {9'h000, cpu_flag_word} :
        (reg_addr_i == IDX_ACTIVE_SP) ? {4'h0, active_sp} :
        RESET_LONG;

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            rdata <= RESET_LONG;
        end else if (reg_read_i) begin
            rdata <= rd_value;
        end else begin
            rdata <= RESET_LONG;
        end
    end
    assign reg_rdata_o = rdata;

    ////////////////////////////////////////////////////////////////////////////
    // core read ports
    logic [DATA_W-1:0] core_rd;
    always_comb begin
        case (core_rsel_i)
            4'(SEL_DATA_ZERO): core_rd = data_reg_zero;
            4'(SEL_DATA_ONE): core_rd = data_reg_one;
            4'(SEL_DATA_TWO): core_rd = data_reg_two;
            4'(SEL_DATA_THREE): core_rd = data_reg_three;
            4'(SEL_ZERO_LOWER): core_rd = {8'h00, data_reg_zero[7:0]};
            4'(SEL_ZERO_UPPER): core_rd = {8'h00, data_reg_zero[15:8]};
            4'(SEL_ONE_LOWER): core_rd = {8'h00, data_reg_one[7:0]};
            4'(SEL_ONE_UPPER): core_rd = {8'h00, data_reg_one[15:8]};
            4'(SEL_ADDR_ZERO): core_rd = addr_reg_zero;
            4'(SEL_ADDR_ONE): core_rd = addr_reg_one;
            4'(SEL_FRAME_BASE): core_rd = frame_base_reg;
            4'(SEL_STATIC_BASE): core_rd = static_base_reg;
            4'(SEL_ACTIVE_SP): core_rd = active_sp;
            default: core_rd = RESET_WORD;
        endcase
    end
    assign core_rdata_o = core_rd;
    assign data_pair_even_o = {data_reg_two, data_reg_zero};
    assign data_pair_odd_o = {data_reg_three, data_reg_one};
    assign addr_pair_long_o = {addr_reg_one, addr_reg_zero};
    assign frame_base_o = frame_base_reg;
    assign static_base_o = static_base_reg;
    assign active_sp_o = active_sp;
    assign vector_base_o = vector_table_base;
    assign instr_ptr_o = next_instr_pointer;
    assign flag_word_o = cpu_flag_word;
endmodule

//--- cpu_regs_checker.sv
// concurrent checks on the ports of the cpu register file
// assumes one clock and the synchronous active low reset of the block
module cpu_regs_checker
    import cpu_regs_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [cpu_regs_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [cpu_regs_pkg::LONG_W-1:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    input wire logic [cpu_regs_pkg::LONG_W-1:0] reg_rdata_o,
    input wire logic pair_we_i,
    input wire logic [1:0] pair_wsel_i,
    input wire logic [31:0] pair_wdata_i,
    input wire logic pc_load_i,
    input wire logic [cpu_regs_pkg::LONG_W-1:0] pc_next_i,
    input wire logic alu_update_i,
    input wire logic alu_carry_i,
    input wire logic alu_overflow_i,
    input wire logic [cpu_regs_pkg::DATA_W-1:0] alu_result_i,
    input wire logic [31:0] data_pair_even_o,
    input wire logic [cpu_regs_pkg::DATA_W-1:0] active_sp_o,
    input wire logic [cpu_regs_pkg::LONG_W-1:0] vector_base_o,
    input wire logic [cpu_regs_pkg::LONG_W-1:0] instr_ptr_o,
    input wire logic [cpu_regs_pkg::FLAG_W-1:0] flag_word_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);
    ////////////////////////////////////////////////////////////////////////////
    zero_flag_a: assert property (alu_update_i |=>
        flag_word_o[FLAG_ZERO] == ($past(alu_result_i) == 16'h0000))
        else $error("zero flag wrong");
    sign_flag_a: assert property (alu_update_i |=>
        flag_word_o[FLAG_SIGN] == $past(alu_result_i[15])) else $error("sign flag wrong");
    carry_flag_a: assert property (alu_update_i |=>
        flag_word_o[FLAG_CARRY] == $past(alu_carry_i)) else $error("carry flag wrong");
    ovfl_flag_a: assert property (alu_update_i |=>
        flag_word_o[FLAG_OVFL] == $past(alu_overflow_i)) else $error("overflow flag wrong");
    flag_write_a: assert property (reg_write_i && reg_addr_i == IDX_FLAG_WORD
        && !alu_update_i |=> flag_word_o == ($past(reg_wdata_i[10:0]) & FLAG_WRITE_MASK))
        else $error("flag write");
    active_sp_a: assert property (reg_read_i && reg_addr_i == IDX_ACTIVE_SP
        |=> reg_rdata_o == {4'h0, $past(active_sp_o)}) else $error("active sp read wrong");
    pc_load_a: assert property (pc_load_i && !reg_write_i
        |=> instr_ptr_o == $past(pc_next_i)) else $error("pc load wrong");
    even_pair_a: assert property (pair_we_i && pair_wsel_i == 2'h0 && !reg_write_i
        |=> data_pair_even_o == $past(pair_wdata_i)) else $error("even pair wrong");
    vec_base_a: assert property (reg_write_i && reg_addr_i == IDX_VECTOR_BASE
        |=> vector_base_o == $past(reg_wdata_i)) else $error("vector base wrong");
    rdata_idle_a: assert property (!reg_read_i |=> reg_rdata_o == 20'h00000)
        else $error("read data not idle");
endmodule
bind cpu_register_file cpu_regs_checker u_chk (.clk_i, .resetn_i, .reg_addr_i, .reg_wdata_i,
    .reg_write_i, .reg_read_i, .reg_rdata_o, .pair_we_i, .pair_wsel_i, .pair_wdata_i, .pc_load_i,
    .pc_next_i, .alu_update_i, .alu_carry_i, .alu_overflow_i, .alu_result_i, .data_pair_even_o,
    .active_sp_o, .vector_base_o, .instr_ptr_o, .flag_word_o);

//--- cpu_regs_pkg.sv
// constants and types of the cpu register file
// assumes one 100 mhz clock and a plain strobe register port
package cpu_regs_pkg;
    localparam int DATA_W = 16;
    localparam int LONG_W = 20;
    localparam int FLAG_W = 11;
    localparam int ADDR_W = 5;
    // register indices on the software port
    localparam logic [4:0] IDX_DATA_ZERO = 5'h00;
    localparam logic [4:0] IDX_DATA_ONE = 5'h01;
    localparam logic [4:0] IDX_DATA_TWO = 5'h02;
    localparam logic [4:0] IDX_DATA_THREE = 5'h03;
    localparam logic [4:0] IDX_ADDR_ZERO = 5'h04;
    localparam logic [4:0] IDX_ADDR_ONE = 5'h05;
    localparam logic [4:0] IDX_FRAME_BASE = 5'h06;
    localparam logic [4:0] IDX_VECTOR_BASE = 5'h07;
    localparam logic [4:0] IDX_INSTR_PTR = 5'h08;
    localparam logic [4:0] IDX_USER_SP = 5'h09;
    localparam logic [4:0] IDX_INTR_SP = 5'h0a;
    localparam logic [4:0] IDX_STATIC_BASE = 5'h0b;
    localparam logic [4:0] IDX_FLAG_WORD = 5'h0c;
    localparam logic [4:0] IDX_ACTIVE_SP = 5'h0d;
    localparam int NUM_BANKED = 7;
    localparam int NUM_BANKS = 2;
    // flag word bit positions
    localparam int FLAG_CARRY = 0;
    localparam int FLAG_DEBUG = 1;
    localparam int FLAG_ZERO = 2;
    localparam int FLAG_SIGN = 3;
    localparam int FLAG_BANK = 4;
    localparam int FLAG_OVFL = 5;
    localparam int FLAG_STACK = 7;
    localparam logic [10:0] FLAG_WRITE_MASK = 11'h7fd;
    // reset values
    localparam logic [15:0] RESET_WORD = 16'h0000;
    localparam logic [19:0] RESET_LONG = 20'h00000;
    localparam logic [10:0] RESET_FLAGS = 11'h000;
    // operand select codes for the core read ports
    typedef enum logic [3:0] {
        SEL_DATA_ZERO, SEL_DATA_ONE, SEL_DATA_TWO, SEL_DATA_THREE,
        SEL_ZERO_LOWER, SEL_ZERO_UPPER, SEL_ONE_LOWER, SEL_ONE_UPPER,
        SEL_ADDR_ZERO, SEL_ADDR_ONE, SEL_FRAME_BASE, SEL_STATIC_BASE,
        SEL_ACTIVE_SP
    } operand_sel_t;
endpackage

//--- testbench.sv
// self-checking bench of the cpu register file
// assumes the strobe register port and core ports as handed over
`define CHK(a, b) checks_done++; if ((a) !== (b)) begin n_fail++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, (a), (b)); end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import cpu_regs_pkg::*;
    logic clk_i, resetn_i = 1'b0, reg_write_i = 1'b0, reg_read_i = 1'b0;
    logic core_we_i = 1'b0, pair_we_i = 1'b0, pc_load_i = 1'b0, alu_update_i = 1'b0;
    logic alu_carry_i = 1'b0, alu_overflow_i = 1'b0;
    logic [4:0] reg_addr_i = 5'h00;
    logic [19:0] reg_wdata_i = 20'h0, pc_next_i = 20'h0, reg_rdata_o;
    logic [19:0] vector_base_o, instr_ptr_o, v, e;
    logic [3:0] core_wsel_i = 4'h0, core_rsel_i = 4'h0;
    logic [1:0] pair_wsel_i = 2'h0;
    logic [15:0] core_wdata_i = 16'h0, alu_result_i = 16'h0, core_rdata_o, frame_base_o;
    logic [15:0] static_base_o, active_sp_o;
    logic [31:0] pair_wdata_i = 32'h0, data_pair_even_o, data_pair_odd_o, addr_pair_long_o;
    logic [10:0] flag_word_o;
    logic [31:0] alu_in [3] = '{32'h00000000, 32'h00018000, 32'h00020001};
    logic [10:0] alu_ex [3] = '{11'h004, 11'h009, 11'h020};
    int n_fail = 0;
    int checks_done = 0;
    cpu_register_file u_dut (.clk_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_write_i,
        .reg_read_i, .reg_rdata_o, .core_we_i, .core_wsel_i, .core_wdata_i, .pair_we_i,
        .pair_wsel_i, .pair_wdata_i, .pc_load_i, .pc_next_i, .alu_update_i, .alu_carry_i,
        .alu_overflow_i, .alu_result_i, .core_rsel_i, .core_rdata_o, .data_pair_even_o,
        .data_pair_odd_o, .addr_pair_long_o, .frame_base_o, .static_base_o, .active_sp_o,
        .vector_base_o, .instr_ptr_o, .flag_word_o);
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [4:0] a, input logic [19:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_write_i <= 1'b1;
        @(posedge clk_i);
        reg_write_i <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [4:0] a, input logic [19:0] x);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_read_i <= 1'b1;
        @(posedge clk_i);
        reg_read_i <= 1'b0;
        #1;
        `CHK(reg_rdata_o, x)
    endtask
    // kind 0 operand, 1 pair, 2 pc load, 3 alu flags
    task automatic core_op(input int k, input logic [3:0] sel, input logic [31:0] d);
        @(posedge clk_i);
        core_wsel_i <= sel;
        pair_wsel_i <= sel[1:0];
        core_wdata_i <= d[15:0];
        pair_wdata_i <= d;
        pc_next_i <= d[19:0];
        alu_result_i <= d[15:0];
        alu_carry_i <= d[16];
        alu_overflow_i <= d[17];
        core_we_i <= (k == 0);
        pair_we_i <= (k == 1);
        pc_load_i <= (k == 2);
        alu_update_i <= (k == 3);
        @(posedge clk_i);
        {core_we_i, pair_we_i, pc_load_i, alu_update_i} <= 4'h0;
        #1;
    endtask
    task automatic stop_test;
        $display("checks %0d fails %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk_i);
        resetn_i <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            v = {4'ha, 4'(i), 12'h3c5};
            e = (i == 7 || i == 8) ? v : {4'h0, v[15:0]};
            rd(5'(i), 20'h0);
            wr(5'(i), v);
            rd(5'(i), e);
        end
        `CHK(frame_base_o, 16'h63c5)
        `CHK(static_base_o, 16'hb3c5)
        `CHK(active_sp_o, 16'ha3c5)
        rd(IDX_ACTIVE_SP, 20'h0a3c5);
        wr(5'h1f, 20'hfffff);
        rd(5'h1f, 20'h0);
        rd(5'h0e, 20'h0);
        $display("register test done");
        wr(IDX_FLAG_WORD, 20'h007ff);
        `CHK(flag_word_o, 11'h7fd)
        rd(IDX_ACTIVE_SP, 20'h093c5);
        rd(IDX_DATA_ZERO, 20'h0);
        wr(IDX_DATA_ZERO, 20'h01234);
        wr(IDX_FLAG_WORD, 20'h0);
        rd(IDX_DATA_ZERO, 20'h003c5);
        wr(IDX_FLAG_WORD, 20'h010);
        rd(IDX_DATA_ZERO, 20'h01234);
        wr(IDX_FLAG_WORD, 20'h0);
        $display("bank test done");
        core_op(1, 4'h0, 32'h11112222);
        `CHK(data_pair_even_o, 32'h11112222)
        rd(IDX_DATA_TWO, 20'h01111);
        core_op(1, 4'h1, 32'h33334444);
        `CHK(data_pair_odd_o, 32'h33334444)
        core_op(1, 4'h2, 32'h55556666);
        `CHK(addr_pair_long_o, 32'h55556666)
        rd(IDX_ADDR_ONE, 20'h05555);
        core_op(0, SEL_ZERO_UPPER, 32'h000000ab);
        @(posedge clk_i);
        core_rsel_i <= SEL_ZERO_UPPER;
        #1;
        `CHK(core_rdata_o, 16'h00ab)
        @(posedge clk_i);
        core_rsel_i <= SEL_DATA_ZERO;
        #1;
        `CHK(core_rdata_o, 16'hab22)
        core_op(0, SEL_ADDR_ZERO, 32'h0000beef);
        rd(IDX_ADDR_ZERO, 20'h0beef);
        core_op(2, 4'h0, 32'h000abcde);
        `CHK(instr_ptr_o, 20'habcde)
        $display("core port test done");
        for (int k = 0; k < 3; k++) begin
            core_op(3, 4'h0, alu_in[k]);
            `CHK(flag_word_o & 11'h02d, alu_ex[k])
        end
        rd(IDX_FLAG_WORD, 20'h00020);
        $display("flag test done");
        stop_test();
    end
endmodule
